/* design/acfec_ctrl.sv */
// gain coefficients, decimation factor and current source control of two converters
// assumes a byte special function register port from the core and mode status from the
// mode control; factory coefficients are stable whenever reset is high
//
// Functional notes
// - primary gain is 24 bits over three bytes, high at EB down to E9.
// - auxiliary gain is 16 bits, high byte at ED, low byte at EC.
// - after reset both gain sets hold the factory coefficient inputs.
// - primary full-scale calibration result overwrites the primary gain bytes.
// - auxiliary full-scale calibration result overwrites the auxiliary gain bytes.
// - software gain writes land only while conversion mode bits are zero.
// - update rate is modulator clock over three times eight times factor.
// - decimation writes are ignored while either converter is active.
// - decimation factor resets to 45.
// - first result appears only after two full update periods.
// - calibration always runs the filter with factor FF.
// - after calibration the programmed factor is used again.
// - control bit 6 enables both burnout sources.
// - control bit 5 enables auxiliary current correction scaling.
// - control bit 4 enables primary current correction scaling.
// - bit 3 steers source two: set to pin a, clear to pin b.
// - bit 2 steers source one: set to pin b, clear to pin a.
// - bit 1 switches source two, bit 0 switches source one.
// - both sources may land on the same pin at once.
`timescale 1ns/1ps
module acfec_ctrl #(
	parameter int MOD_DIV = acfec_pkg::MOD_DIV
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr_en,
	input wire logic sfr_rd_en,
	output logic [7:0] sfr_rdata,
	// mode control status
	input wire logic [2:0] conversion_mode_bits,
	input wire logic primary_active,
	input wire logic aux_active,
	input wire logic calibrating,
	// factory coefficients
	input wire logic [23:0] primary_factory_gain,
	input wire logic [15:0] aux_factory_gain,
	// full-scale calibration results
	input wire logic primary_fs_cal_done,
	input wire logic [23:0] primary_fs_cal_gain,
	input wire logic aux_fs_cal_done,
	input wire logic [15:0] aux_fs_cal_gain,
	// coefficients and filter setting to the converters
	output logic [23:0] primary_gain,
	output logic [15:0] aux_gain,
	output logic [7:0] filter_decimation,
	output logic update_tick,
	output logic result_ready,
	// current source switches
	output logic burnout_enable,
	output logic aux_current_correction,
	output logic primary_current_correction,
	output logic src1_to_pin_a,
	output logic src1_to_pin_b,
	output logic src2_to_pin_a,
	output logic src2_to_pin_b
);

	localparam int BW = acfec_pkg::BYTE_W;

	logic [acfec_pkg::PRIMARY_GAIN_W-1:0] primary_gain_reg;
	logic [acfec_pkg::AUX_GAIN_W-1:0] aux_gain_reg;
	logic [7:0] decimation_factor_reg;
	logic [acfec_pkg::CURRENT_CONTROL_W-1:0] current_source_control_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [acfec_pkg::MOD_DIV_W-1:0] mod_cnt_reg;
	logic mod_tick_reg;
	logic [7:0] decim_eff_reg;
	logic mode_idle;
	logic conv_active;
	logic wr_pl;
	logic wr_pm;
	logic wr_ph;
	logic wr_al;
	logic wr_ah;
	logic wr_decim;
	logic wr_current_source_control;

	acfec_rate_if rate_bus ();

	acfec_rate_timer u_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.rs(rate_bus.timer)
	);

	////////////////////////////////////////////////////////////////////////////////
	// write decode

	assign mode_idle = (conversion_mode_bits == acfec_pkg::MODE_IDLE);
	assign conv_active = primary_active || aux_active;
	assign wr_pl = sfr_wr_en && sfr_addr == acfec_pkg::ADDR_PRIMARY_GAIN_LOW && mode_idle;
	assign wr_pm = sfr_wr_en && sfr_addr == acfec_pkg::ADDR_PRIMARY_GAIN_MID && mode_idle;
	assign wr_ph = sfr_wr_en && sfr_addr == acfec_pkg::ADDR_PRIMARY_GAIN_HIGH && mode_idle;
	assign wr_al = sfr_wr_en && sfr_addr == acfec_pkg::ADDR_AUX_GAIN_LOW && mode_idle;
	assign wr_ah = sfr_wr_en && sfr_addr == acfec_pkg::ADDR_AUX_GAIN_HIGH && mode_idle;
	assign wr_decim = sfr_wr_en && sfr_addr == acfec_pkg::ADDR_DECIMATION_FACTOR &&
		!conv_active;
	assign wr_current_source_control = sfr_wr_en && sfr_addr == acfec_pkg::ADDR_CURRENT_SOURCE_CONTROL;

	////////////////////////////////////////////////////////////////////////////////
	// gain coefficients: calibration result wins over a software byte in the same cycle

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			primary_gain_reg <= primary_factory_gain;
		end else if (primary_fs_cal_done) begin
			primary_gain_reg <= primary_fs_cal_gain;
		end else begin
			if (wr_ph) begin
				primary_gain_reg[2*BW +: BW] <= sfr_wdata;
			end
			if (wr_pm) begin
				primary_gain_reg[BW +: BW] <= sfr_wdata;
			end
			if (wr_pl) begin
				primary_gain_reg[0 +: BW] <= sfr_wdata;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aux_gain_reg <= aux_factory_gain;
		end else if (aux_fs_cal_done) begin
			aux_gain_reg <= aux_fs_cal_gain;
		end else begin
			if (wr_ah) begin
				aux_gain_reg[BW +: BW] <= sfr_wdata;
			end
			if (wr_al) begin
				aux_gain_reg[0 +: BW] <= sfr_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decimation factor; out-of-range values are stored as written, software keeps range

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			decimation_factor_reg <= acfec_pkg::DECIMATION_RESET;
		end else if (wr_decim) begin
			decimation_factor_reg <= sfr_wdata;
		end
	end

	// stored value is never touched by calibration, so it returns by itself afterwards
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			decim_eff_reg <= acfec_pkg::DECIMATION_RESET;
		end else if (calibrating) begin
			decim_eff_reg <= acfec_pkg::DECIMATION_CAL;
		end else begin
			decim_eff_reg <= decimation_factor_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// current source control, bit 7 reserved and not stored

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			current_source_control_reg <=
				acfec_pkg::CURRENT_CONTROL_RESET[acfec_pkg::CURRENT_CONTROL_W-1:0];
		end else if (wr_current_source_control) begin
			current_source_control_reg <= sfr_wdata[acfec_pkg::CURRENT_CONTROL_W-1:0];
		end
	end

	always_comb begin
		burnout_enable = current_source_control_reg[acfec_pkg::BIT_BURNOUT];
		aux_current_correction = current_source_control_reg[acfec_pkg::BIT_AUX_CORR];
		primary_current_correction =
			current_source_control_reg[acfec_pkg::BIT_PRIMARY_CORR];
		// routing of each source is independent, so both may share one pin
		src2_to_pin_a = current_source_control_reg[acfec_pkg::BIT_SRC2_EN] &&
			current_source_control_reg[acfec_pkg::BIT_SRC2_PIN];
		src2_to_pin_b = current_source_control_reg[acfec_pkg::BIT_SRC2_EN] &&
			!current_source_control_reg[acfec_pkg::BIT_SRC2_PIN];
		src1_to_pin_b = current_source_control_reg[acfec_pkg::BIT_SRC1_EN] &&
			current_source_control_reg[acfec_pkg::BIT_SRC1_PIN];
		src1_to_pin_a = current_source_control_reg[acfec_pkg::BIT_SRC1_EN] &&
			!current_source_control_reg[acfec_pkg::BIT_SRC1_PIN];
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path, one cycle latency, unmapped reads return zero

	always_comb begin
		rdata_next = acfec_pkg::READ_UNMAPPED;
		case (sfr_addr)
			acfec_pkg::ADDR_PRIMARY_GAIN_HIGH: rdata_next = primary_gain_reg[2*BW +: BW];
			acfec_pkg::ADDR_PRIMARY_GAIN_MID: rdata_next = primary_gain_reg[BW +: BW];
			acfec_pkg::ADDR_PRIMARY_GAIN_LOW: rdata_next = primary_gain_reg[0 +: BW];
			acfec_pkg::ADDR_AUX_GAIN_HIGH: rdata_next = aux_gain_reg[BW +: BW];
			acfec_pkg::ADDR_AUX_GAIN_LOW: rdata_next = aux_gain_reg[0 +: BW];
			acfec_pkg::ADDR_DECIMATION_FACTOR: rdata_next = decimation_factor_reg;
			acfec_pkg::ADDR_CURRENT_SOURCE_CONTROL: rdata_next = {1'b0, current_source_control_reg};
			default: rdata_next = acfec_pkg::READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_reg <= acfec_pkg::READ_UNMAPPED;
		end else if (sfr_rd_en) begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// modulator clock enable; integer divide makes it a shade fast of 32.768 kHz

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mod_cnt_reg <= '0;
			mod_tick_reg <= 1'b0;
		end else if (mod_cnt_reg == acfec_pkg::MOD_DIV_W'(MOD_DIV - 1)) begin
			mod_cnt_reg <= '0;
			mod_tick_reg <= 1'b1;
		end else begin
			mod_cnt_reg <= mod_cnt_reg + 11'h001;
			mod_tick_reg <= 1'b0;
		end
	end

	assign rate_bus.decim = decim_eff_reg;
	assign rate_bus.run = conv_active || calibrating;
	assign rate_bus.mod_tick = mod_tick_reg;

	assign sfr_rdata = rdata_reg;
	assign primary_gain = primary_gain_reg;
	assign aux_gain = aux_gain_reg;
	assign filter_decimation = decim_eff_reg;
	assign update_tick = rate_bus.update_tick;
	assign result_ready = rate_bus.result_ready;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_primary_gain_guard: assert property (@(posedge clock) disable iff (sys_rst)
		(!mode_idle && !primary_fs_cal_done) |=> $stable(primary_gain_reg))
		else $error("primary gain changed while protected");

	a_aux_gain_guard: assert property (@(posedge clock) disable iff (sys_rst)
		(!mode_idle && !aux_fs_cal_done) |=> $stable(aux_gain_reg))
		else $error("auxiliary gain changed while protected");

	a_primary_cal_load: assert property (@(posedge clock) disable iff (sys_rst)
		primary_fs_cal_done |=> primary_gain == $past(primary_fs_cal_gain))
		else $error("primary calibration result not loaded");

	a_aux_cal_load: assert property (@(posedge clock) disable iff (sys_rst)
		aux_fs_cal_done |=> aux_gain == $past(aux_fs_cal_gain))
		else $error("auxiliary calibration result not loaded");

	a_gain_high_write: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_ph && !primary_fs_cal_done) |=> primary_gain[2*BW +: BW] == $past(sfr_wdata))
		else $error("primary high byte write lost");

	a_aux_high_write: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_ah && !aux_fs_cal_done) |=> aux_gain[BW +: BW] == $past(sfr_wdata))
		else $error("auxiliary high byte write lost");

	a_decim_accept: assert property (@(posedge clock) disable iff (sys_rst)
		wr_decim |=> decimation_factor_reg == $past(sfr_wdata))
		else $error("decimation write lost while idle");

	a_decim_reject: assert property (@(posedge clock) disable iff (sys_rst)
		conv_active |=> $stable(decimation_factor_reg))
		else $error("decimation changed while converting");

	a_decim_cal_max: assert property (@(posedge clock) disable iff (sys_rst)
		calibrating [*2] |-> filter_decimation == acfec_pkg::DECIMATION_CAL)
		else $error("calibration not run at maximum decimation");

	a_decim_restore: assert property (@(posedge clock) disable iff (sys_rst)
		(!calibrating && $past(!calibrating)) |-> filter_decimation == $past(decimation_factor_reg))
		else $error("programmed decimation not restored");

	a_decim_reset: assert property (@(posedge clock)
		sys_rst |=> decimation_factor_reg == acfec_pkg::DECIMATION_RESET)
		else $error("decimation reset value wrong");

	// tied to the divider wrap rather than a fixed gap, so a shortened divider still holds
	a_mod_tick_single: assert property (@(posedge clock) disable iff (sys_rst)
		mod_tick_reg |-> (mod_cnt_reg == '0) ##1 !mod_tick_reg)
		else $error("modulator enable too frequent");

	a_source_route: assert property (@(posedge clock) disable iff (sys_rst)
		!(src1_to_pin_a && src1_to_pin_b) && !(src2_to_pin_a && src2_to_pin_b))
		else $error("one source driven to two pins");

endmodule

/* design/acfec_pkg.sv */
// constants shared by the converter control block and its update-rate timer
// assumes one 40 MHz core clock and a byte-wide special function register port
package acfec_pkg;

	// special function register addresses
	localparam logic [7:0] ADDR_CURRENT_SOURCE_CONTROL = 8'hD5;
	localparam logic [7:0] ADDR_DECIMATION_FACTOR = 8'hD4;
	localparam logic [7:0] ADDR_PRIMARY_GAIN_LOW = 8'hE9;
	localparam logic [7:0] ADDR_PRIMARY_GAIN_MID = 8'hEA;
	localparam logic [7:0] ADDR_PRIMARY_GAIN_HIGH = 8'hEB;
	localparam logic [7:0] ADDR_AUX_GAIN_LOW = 8'hEC;
	localparam logic [7:0] ADDR_AUX_GAIN_HIGH = 8'hED;

	// reset values, calibration and minimum decimation factors, unmapped read value
	localparam logic [7:0] CURRENT_CONTROL_RESET = 8'h00;
	localparam logic [7:0] DECIMATION_RESET = 8'h45;
	localparam logic [7:0] DECIMATION_CAL = 8'hFF;
	localparam logic [7:0] DECIMATION_MIN = 8'h0D;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// conversion mode field value in which the gain bytes accept writes
	localparam logic [2:0] MODE_IDLE = 3'h0;

	// current source control field positions
	localparam int BIT_BURNOUT = 6;
	localparam int BIT_AUX_CORR = 5;
	localparam int BIT_PRIMARY_CORR = 4;
	localparam int BIT_SRC2_PIN = 3;
	localparam int BIT_SRC1_PIN = 2;
	localparam int BIT_SRC2_EN = 1;
	localparam int BIT_SRC1_EN = 0;
	localparam int CURRENT_CONTROL_W = 7;

	// byte lanes of the gain words
	localparam int BYTE_W = 8;
	localparam int PRIMARY_GAIN_W = 24;
	localparam int AUX_GAIN_W = 16;

	// timing: modulator clock and update period of three times eight times the factor
	localparam longint CLOCK_HZ = 40000000;
	localparam longint MOD_CLOCK_HZ = 32768;
	localparam int MOD_DIV = int'(CLOCK_HZ / MOD_CLOCK_HZ);
	localparam int MOD_DIV_W = 11;
	localparam int PERIOD_W = 13;
	localparam logic [PERIOD_W-1:0] UPDATE_MULT = 13'h0018;
	localparam logic [1:0] FIRST_RESULT_PERIODS = 2'h2;

endpackage

/* design/acfec_rate_if.sv */
// carrier between the control registers and the update-rate timer
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface acfec_rate_if;
	logic [7:0] decim;
	logic run;
	logic mod_tick;
	logic update_tick;
	logic result_ready;

	modport ctrl (
		output decim,
		output run,
		output mod_tick,
		input update_tick,
		input result_ready
	);

	modport timer (
		input decim,
		input run,
		input mod_tick,
		output update_tick,
		output result_ready
	);
endinterface

/* design/acfec_rate_timer.sv */
// output update timer: counts modulator ticks per update period of the sinc filter
// assumes mod_tick is a one-cycle enable and run stays high for a whole conversion
`timescale 1ns/1ps
module acfec_rate_timer (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// timer side of the rate carrier
	acfec_rate_if.timer rs
);

	logic [acfec_pkg::PERIOD_W-1:0] cnt_reg;
	logic [acfec_pkg::PERIOD_W-1:0] period;
	logic [1:0] seen_reg;
	logic period_end;
	logic update_reg;
	logic ready_reg;

	assign period = acfec_pkg::PERIOD_W'(rs.decim) * acfec_pkg::UPDATE_MULT;
	assign period_end = rs.run && rs.mod_tick && (cnt_reg == period - 13'h0001);
	assign rs.update_tick = update_reg;
	assign rs.result_ready = ready_reg;

	////////////////////////////////////////////////////////////////////////////////
	// period counter restarts whenever the converters stop

	always_ff @(posedge clock) begin
		if (sys_rst || !rs.run) begin
			cnt_reg <= '0;
		end else if (period_end) begin
			cnt_reg <= '0;
		end else if (rs.mod_tick) begin
			cnt_reg <= cnt_reg + 13'h0001;
		end
	end

	// chopping needs two full periods before the first valid word
	always_ff @(posedge clock) begin
		if (sys_rst || !rs.run) begin
			seen_reg <= '0;
		end else if (period_end && seen_reg != acfec_pkg::FIRST_RESULT_PERIODS) begin
			seen_reg <= seen_reg + 2'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			update_reg <= 1'b0;
			ready_reg <= 1'b0;
		end else begin
			update_reg <= period_end;
			ready_reg <= period_end &&
				(seen_reg + 2'h1 >= acfec_pkg::FIRST_RESULT_PERIODS);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_first_result_late: assert property (@(posedge clock) disable iff (sys_rst)
		(period_end && seen_reg == 2'h0) |=> !ready_reg)
		else $error("result ready before two update periods");

	a_period_tick_follows: assert property (@(posedge clock) disable iff (sys_rst)
		period_end |=> update_reg)
		else $error("update tick missing at period end");

	a_ready_with_tick: assert property (@(posedge clock) disable iff (sys_rst)
		ready_reg |-> update_reg && $past(seen_reg) != 2'h0)
		else $error("result ready without a completed second period");

endmodule

/* tb/tb_acfec_ctrl.sv */
// self-checking bench for the converter control block: registers, calibration, rate timer
// assumes the design files are compiled first; the modulator divider is shortened to 4
`timescale 1ns/1ps
module tb_acfec_ctrl;
	localparam int MD = 4;
	localparam int T_LIM = 90000;
	localparam int F_LO = 13;
	localparam int F_HI = 255;

	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr_en = 1'b0;
	logic sfr_rd_en = 1'b0;
	logic [7:0] sfr_rdata;
	logic [2:0] conversion_mode_bits = 3'h0;
	logic primary_active = 1'b0;
	logic aux_active = 1'b0;
	logic calibrating = 1'b0;
	logic [23:0] primary_factory_gain = 24'h000000;
	logic [15:0] aux_factory_gain = 16'h0000;
	logic primary_fs_cal_done = 1'b0;
	logic [23:0] primary_fs_cal_gain = 24'h000000;
	logic aux_fs_cal_done = 1'b0;
	logic [15:0] aux_fs_cal_gain = 16'h0000;
	logic [23:0] primary_gain;
	logic [15:0] aux_gain;
	logic [7:0] filter_decimation;
	logic update_tick;
	logic result_ready;
	logic burnout_enable;
	logic aux_current_correction;
	logic primary_current_correction;
	logic src1_to_pin_a;
	logic src1_to_pin_b;
	logic src2_to_pin_a;
	logic src2_to_pin_b;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	integer seed = 32'h024F1B26;

	always #12.5 clock = ~clock;

	acfec_ctrl #(.MOD_DIV(MD)) uut (
		.clock(clock), .sys_rst(sys_rst),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr_en(sfr_wr_en),
		.sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata),
		.conversion_mode_bits(conversion_mode_bits), .primary_active(primary_active),
		.aux_active(aux_active), .calibrating(calibrating),
		.primary_factory_gain(primary_factory_gain), .aux_factory_gain(aux_factory_gain),
		.primary_fs_cal_done(primary_fs_cal_done), .primary_fs_cal_gain(primary_fs_cal_gain),
		.aux_fs_cal_done(aux_fs_cal_done), .aux_fs_cal_gain(aux_fs_cal_gain),
		.primary_gain(primary_gain), .aux_gain(aux_gain),
		.filter_decimation(filter_decimation), .update_tick(update_tick),
		.result_ready(result_ready), .burnout_enable(burnout_enable),
		.aux_current_correction(aux_current_correction),
		.primary_current_correction(primary_current_correction),
		.src1_to_pin_a(src1_to_pin_a), .src1_to_pin_b(src1_to_pin_b),
		.src2_to_pin_a(src2_to_pin_a), .src2_to_pin_b(src2_to_pin_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard: the calibration periods dominate, about 52k cycles in all
	always @(posedge clock) begin
		cyc++;
		if (cyc == T_LIM) begin
			n_fail++;
			$display("BAD timeout expected %0d seen %0d", T_LIM - 1, cyc);
			end_sim();
		end
	end

	// strobe high for one edge; #1 lets that edge's register updates land before sampling
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr_en <= 1'b1;
		@(posedge clock);
		sfr_wr_en <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd_en <= 1'b1;
		@(posedge clock);
		sfr_rd_en <= 1'b0;
		#1;
		check(what, 32'(sfr_rdata), 32'(e));
	endtask

	task automatic wr_gain(input logic [23:0] p, input logic [15:0] x);
		wr(acfec_pkg::ADDR_PRIMARY_GAIN_HIGH, p[23:16]);
		wr(acfec_pkg::ADDR_PRIMARY_GAIN_MID, p[15:8]);
		wr(acfec_pkg::ADDR_PRIMARY_GAIN_LOW, p[7:0]);
		wr(acfec_pkg::ADDR_AUX_GAIN_HIGH, x[15:8]);
		wr(acfec_pkg::ADDR_AUX_GAIN_LOW, x[7:0]);
	endtask

	task automatic chk_gain(input logic [23:0] p, input logic [15:0] x);
		check("primary gain", 32'(primary_gain), 32'(p));
		check("aux gain", 32'(aux_gain), 32'(x));
		rd_chk("gain high", acfec_pkg::ADDR_PRIMARY_GAIN_HIGH, p[23:16]);
		rd_chk("gain mid", acfec_pkg::ADDR_PRIMARY_GAIN_MID, p[15:8]);
		rd_chk("gain low", acfec_pkg::ADDR_PRIMARY_GAIN_LOW, p[7:0]);
		rd_chk("aux high", acfec_pkg::ADDR_AUX_GAIN_HIGH, x[15:8]);
		rd_chk("aux low", acfec_pkg::ADDR_AUX_GAIN_LOW, x[7:0]);
	endtask

	// edges counted up to and including the next update tick, bounded
	task automatic wait_tick(output int n, output logic rr);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (update_tick !== 1'b1 && n < 24 * F_HI * MD + 20);
		rr = result_ready;
	endtask

	// pin a is the output-DAC pin, pin b the fifth-input pin
	function automatic logic [6:0] exp_current_source_control(input logic [7:0] b);
		return {b[6], b[5], b[4], b[1] & ~b[3], b[1] & b[3], b[0] & b[2], b[0] & ~b[2]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin : main
		logic [23:0] pf;
		logic [15:0] af;
		logic [23:0] p;
		logic [15:0] x;
		logic [7:0] b;
		logic rr;
		int n;
		pf = 24'($random(seed));
		af = 16'($random(seed));
		primary_factory_gain = pf;
		aux_factory_gain = af;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		rd_chk("control reset", acfec_pkg::ADDR_CURRENT_SOURCE_CONTROL, 8'h00);
		rd_chk("decimation reset", acfec_pkg::ADDR_DECIMATION_FACTOR, 8'h45);
		rd_chk("unmapped read", 8'h00, 8'h00);
		chk_gain(pf, af);
		$display("test reset done");
		p = 24'hFFFFFF;
		x = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			wr_gain(p, x);
			chk_gain(p, x);
			p = 24'($random(seed));
			x = 16'($random(seed));
		end
		wr_gain(p, x);
		for (int m = 1; m < 8; m++) begin
			conversion_mode_bits <= 3'(m);
			wr_gain(~p, ~x);
			chk_gain(p, x);
		end
		$display("test gain protection done");
		p = 24'($random(seed));
		x = 16'($random(seed));
		@(posedge clock);
		primary_fs_cal_gain <= p;
		primary_fs_cal_done <= 1'b1;
		@(posedge clock);
		primary_fs_cal_done <= 1'b0;
		aux_fs_cal_gain <= x;
		aux_fs_cal_done <= 1'b1;
		@(posedge clock);
		aux_fs_cal_done <= 1'b0;
		primary_fs_cal_gain <= ~p;
		aux_fs_cal_gain <= ~x;
		#1;
		chk_gain(p, x);
		conversion_mode_bits <= 3'h0;
		$display("test calibration load done");
		wr(acfec_pkg::ADDR_DECIMATION_FACTOR, 8'h0D);
		for (int k = 1; k < 4; k++) begin
			primary_active <= k[0];
			aux_active <= k[1];
			wr(acfec_pkg::ADDR_DECIMATION_FACTOR, 8'hFF);
			rd_chk("refused decimation", acfec_pkg::ADDR_DECIMATION_FACTOR, 8'h0D);
		end
		aux_active <= 1'b0;
		repeat (2) @(posedge clock);
		primary_active <= 1'b0;
		repeat (2) @(posedge clock);
		primary_active <= 1'b1;
		wait_tick(n, rr);
		check("first period near", 32'(n >= 24 * F_LO * MD - MD && n <= 24 * F_LO * MD + MD + 4), 32'h1);
		check("no result after one period", 32'(rr), 32'h0);
		wait_tick(n, rr);
		check("update period", 32'(n), 32'(24 * F_LO * MD));
		check("result after two periods", 32'(rr), 32'h1);
		primary_active <= 1'b0;
		$display("test update rate done");
		repeat (2) @(posedge clock);
		calibrating <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		check("calibration factor", 32'(filter_decimation), 32'h0000_00FF);
		wait_tick(n, rr);
		wait_tick(n, rr);
		check("calibration period", 32'(n), 32'(24 * F_HI * MD));
		calibrating <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check("factor after calibration", 32'(filter_decimation), 32'h0000_000D);
		rd_chk("stored after calibration", acfec_pkg::ADDR_DECIMATION_FACTOR, 8'h0D);
		$display("test calibration rate done");
		for (int i = 0; i < 128; i++) begin
			b = 8'(i) | (8'($random(seed)) & 8'h80);
			wr(acfec_pkg::ADDR_CURRENT_SOURCE_CONTROL, b);
			check("source switches", 32'({burnout_enable, aux_current_correction,
				primary_current_correction, src2_to_pin_b, src2_to_pin_a, src1_to_pin_b,
				src1_to_pin_a}), 32'(exp_current_source_control(b)));
			rd_chk("control readback", acfec_pkg::ADDR_CURRENT_SOURCE_CONTROL, b & 8'h7F);
		end
		$display("test current sources done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd_chk("decimation second reset", acfec_pkg::ADDR_DECIMATION_FACTOR, 8'h45);
		rd_chk("control second reset", acfec_pkg::ADDR_CURRENT_SOURCE_CONTROL, 8'h00);
		chk_gain(pf, af);
		$display("test second reset done");
		end_sim();
	end
endmodule
